// >>> wd_periodic_pkg.sv
/*
 * constants for the watchdog and periodic interrupt timer: register
 * offsets, field positions, reset values, key codes and tap choices.
 * assumes an 8-bit register port with byte-wide offsets.
 */
package wd_periodic_pkg;

    // register offsets (low byte of the peripheral address)
    localparam logic [7:0] off_periodic_count = 8'h21;
    localparam logic [7:0] off_watchdog_count = 8'h23;
    localparam logic [7:0] off_service_key = 8'h25;
    localparam logic [7:0] off_periodic_control = 8'h27;
    localparam logic [7:0] off_watchdog_control = 8'h29;

    // service key codes
    localparam logic [7:0] key_arm = 8'h55;
    localparam logic [7:0] key_clear = 8'haa;

    // watchdog_control fields
    localparam int wdc_cause_bit = 7;
    localparam int wdc_defeat_bit = 6;
    localparam int wdc_pattern_hi = 5;
    localparam int wdc_pattern_lo = 3;
    localparam logic [2:0] integrity_pattern = 3'h5;
    localparam logic [2:0] watchdog_rate_reset = 3'h0;

    // periodic_control fields
    localparam int pc_flag_bit = 7;
    localparam int pc_allow_bit = 6;
    localparam logic [2:0] periodic_rate_reset = 3'h0;

    // prescale layout
    localparam int free_width = 7;
    localparam int count_width = 8;
    // free-running taps feeding the periodic mux (carry out of n bits)
    localparam int ptap_free_0 = 2;
    localparam int ptap_free_1 = 4;
    localparam int ptap_free_2 = 6;
    localparam int ptap_free_3 = 7;
    // periodic_count taps (carry out of m low bits of the count)
    localparam int ptap_cnt_0 = 1;
    localparam int ptap_cnt_1 = 3;
    localparam int ptap_cnt_2 = 5;
    localparam int ptap_cnt_3 = 7;

    // nominal slow tick rate, for reference only
    localparam int slow_tick_hz = 16384;

endpackage

// >>> wd_periodic_timer.sv
/*
 * watchdog and periodic interrupt timer. a 7-bit free-running prescale
 * on the slow tick feeds an 8-bit watchdog count and an 8-bit periodic
 * count. watchdog resets come from overflow, a bad service key or a
 * damaged integrity pattern.
 * assumes: slow_tick is a one-cycle enable from logic on clk; the
 * system reset controller answers system_reset_req by pulsing reset;
 * power_on_reset is raised only at power up.
 */
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps

// Operation
// - watchdog count: 8-bit, readable, counts selected tap
// - free prescale advances every tick, reset only
// - rate select: direct tick or six taps
// - 55h arms, next AAh clears count
// - any 55h/AAh mix causes no reset
// - any other key value resets at once
// - overflow or bad key sets surviving cause flag
// - cause flag never blocks later resets
// - overflow resets one selected tick later
// - overflow reset unmaskable; stops without tick
// - defeat works only with supply strap high
// - integrity bits not 101 force reset
// - reset: fastest rate, counting starts at once
// - periodic count steps on divide-by-128 carry
// - 1-of-8 mux: four count, four free taps
// - taps span 1 to 4096 per second
// - periodic count readable, write clears it
// - one request per selected tap transition
// - periodic part runs except in halt
// - flag set by overflow, cleared writing 0
// - clearing allow withdraws pending request
module wd_periodic_timer
    import wd_periodic_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic power_on_reset,
    input wire logic slow_tick,
    input wire logic halt,
    input wire logic programming_supply_pin,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    output logic periodic_irq,
    input wire logic periodic_irq_ack,
    output logic system_reset_req,
    output logic watchdog_reset_cause
);

    // all state set by system reset, cleared except pattern (101)
    typedef struct packed {
        logic [free_width-1:0] free_count;   // shared prescale
        logic [count_width-1:0] watchdog_count;
        logic [count_width-1:0] periodic_count;
        logic armed;                         // 55h seen, AAh pending
        logic overflow_pending;              // waits one selected tick
        logic [2:0] watchdog_rate_select;
        logic watchdog_defeat;
        logic [2:0] pattern;                 // integrity bits as stored
        logic [2:0] periodic_rate_select;
        logic periodic_overflow_seen;
        logic periodic_irq_allow;
        logic irq_pending;
        logic [7:0] read_data;
        logic reset_req;
    } state_t;

    // state kept across system reset, cleared at power up only
    typedef struct packed {
        logic [2:0] supply_sync;             // pin synchroniser
        logic supply_level;                  // filtered pin level
        logic strap;                         // level caught during reset
        logic cause;                         // watchdog reset cause
    } keep_t;

    state_t state;
    state_t next_state;
    keep_t keep;
    keep_t next_keep;

    // watchdog reset event that also marks the cause
    logic cause_event;

    // carry out of the low n bits of a counter on an advance
    function automatic logic carry_out(
        input logic [count_width-1:0] value,
        input int n,
        input logic advance
    );
        logic all_ones;
        all_ones = 1'b1;
        for (int i = 0; i < count_width; i++)
        begin
            if (i < n)
            begin
                all_ones = all_ones & value[i];
            end
        end
        return advance & all_ones;
    endfunction

    // write strobe aimed at one register offset
    function automatic logic write_hit(
        input logic strobe,
        input logic [7:0] where,
        input logic [7:0] target
    );
        return strobe && (where == target);
    endfunction

    // read view of watchdog control, shown at two offsets
    function automatic logic [7:0] wd_control_view(
        input state_t s,
        input logic cause
    );
        return {cause, s.watchdog_defeat, s.pattern,
                s.watchdog_rate_select};
    endfunction

    // next state of the reset-domain logic
    always_comb
    begin
        logic [count_width-1:0] free_wide;
        logic wd_tick;
        logic periodic_advance;
        logic count_tick;
        logic tap;
        logic key_write;
        logic key_bad;
        logic overflow_fire;
        logic defeated;
        logic periodic_run;
        free_wide = '0;
        wd_tick = 1'b0;
        periodic_advance = 1'b0;
        count_tick = 1'b0;
        tap = 1'b0;
        key_write = 1'b0;
        key_bad = 1'b0;
        overflow_fire = 1'b0;
        defeated = 1'b0;
        periodic_run = 1'b0;
        next_state = state;

        // free prescale runs on every tick, only reset clears it
        free_wide = {1'b0, state.free_count};
        if (slow_tick)
        begin
            next_state.free_count = state.free_count + 1'b1;
        end

        // watchdog clock: codes 0,1 direct, 2..7 carry of 1..6 bits
        case (state.watchdog_rate_select)
            3'h0, 3'h1: wd_tick = slow_tick;
            default:
                wd_tick = carry_out(free_wide,
                    int'(state.watchdog_rate_select) - 1, slow_tick);
        endcase

        // defeat honoured only with the strap caught in reset
        defeated = state.watchdog_defeat & keep.strap;

        // count on the selected tap unless defeated
        if (wd_tick && !defeated)
        begin
            next_state.watchdog_count = state.watchdog_count + 1'b1;
            if (state.overflow_pending)
            begin
                overflow_fire = 1'b1;
            end
            else if (state.watchdog_count == 8'hff)
            begin
                next_state.overflow_pending = 1'b1;
            end
        end

        // service key handling
        key_write = write_hit(wr, addr, off_service_key);
        if (key_write)
        begin
            if (wdata == key_arm)
            begin
                next_state.armed = 1'b1;
            end
            else if (wdata == key_clear)
            begin
                // clear only when armed, otherwise ignored
                if (state.armed)
                begin
                    next_state.watchdog_count = '0;
                    next_state.overflow_pending = 1'b0;
                    next_state.armed = 1'b0;
                end
            end
            else
            begin
                key_bad = 1'b1;
            end
        end

        // watchdog control write; pattern kept as written
        if (write_hit(wr, addr, off_watchdog_control))
        begin
            next_state.watchdog_rate_select = wdata[2:0];
            next_state.watchdog_defeat = wdata[wdc_defeat_bit];
            next_state.pattern = wdata[wdc_pattern_hi:wdc_pattern_lo];
        end

        // reset request: cause flag never gates it
        cause_event = key_bad | overflow_fire;
        next_state.reset_req = cause_event
            | (state.pattern != integrity_pattern);

        // periodic part stops only in halt
        periodic_run = !halt;
        periodic_advance = carry_out(free_wide, ptap_free_3,
            slow_tick & periodic_run);
        if (periodic_advance)
        begin
            next_state.periodic_count = state.periodic_count + 1'b1;
        end

        // 1-of-8 tap mux: 0..3 free taps, 4..7 count taps
        count_tick = periodic_advance;
        case (state.periodic_rate_select)
            3'h0: tap = carry_out(free_wide, ptap_free_0,
                slow_tick & periodic_run);
            3'h1: tap = carry_out(free_wide, ptap_free_1,
                slow_tick & periodic_run);
            3'h2: tap = carry_out(free_wide, ptap_free_2,
                slow_tick & periodic_run);
            3'h3: tap = periodic_advance;
            3'h4: tap = carry_out(state.periodic_count, ptap_cnt_0,
                count_tick);
            3'h5: tap = carry_out(state.periodic_count, ptap_cnt_1,
                count_tick);
            3'h6: tap = carry_out(state.periodic_count, ptap_cnt_2,
                count_tick);
            3'h7: tap = carry_out(state.periodic_count, ptap_cnt_3,
                count_tick);
            default: tap = 1'b0;
        endcase

        // any write clears the periodic count, free prescale untouched
        if (write_hit(wr, addr, off_periodic_count))
        begin
            next_state.periodic_count = '0;
        end

        // periodic control write; flag only written, never raises irq
        if (write_hit(wr, addr, off_periodic_control))
        begin
            next_state.periodic_rate_select = wdata[2:0];
            next_state.periodic_irq_allow = wdata[pc_allow_bit];
            next_state.periodic_overflow_seen = wdata[pc_flag_bit];
            if (!wdata[pc_allow_bit])
            begin
                next_state.irq_pending = 1'b0;
            end
        end

        // acknowledge drops the request
        if (periodic_irq_ack)
        begin
            next_state.irq_pending = 1'b0;
        end

        // overflow flag set wins over the software clear
        if (tap)
        begin
            next_state.periodic_overflow_seen = 1'b1;
        end

        // one request per tap pulse, independent of the flag
        if (tap && state.periodic_irq_allow
            && !(wr && (addr == off_periodic_control)
                 && !wdata[pc_allow_bit]))
        begin
            next_state.irq_pending = 1'b1;
        end

        // read data for the cycle after the strobe
        next_state.read_data = 8'h00;
        if (rd)
        begin
            case (addr)
                off_periodic_count:
                    next_state.read_data = state.periodic_count;
                off_watchdog_count:
                    next_state.read_data = state.watchdog_count;
                off_service_key:
                    next_state.read_data = wd_control_view(state, keep.cause);
                off_periodic_control:
                    next_state.read_data = {state.periodic_overflow_seen,
                        state.periodic_irq_allow, 3'h0,
                        state.periodic_rate_select};
                off_watchdog_control:
                    next_state.read_data = wd_control_view(state, keep.cause);
                default:
                    next_state.read_data = 8'h00;
            endcase
        end
    end

    // power-up domain: pin filter, strap capture and cause flag
    always_comb
    begin
        next_keep = keep;
        next_keep.supply_sync = {keep.supply_sync[1:0],
            programming_supply_pin};
        // a change counts once the second and third stages agree
        if (keep.supply_sync[1] == keep.supply_sync[2])
        begin
            next_keep.supply_level = keep.supply_sync[1];
        end
        // strap follows the pin while system reset is held
        if (reset)
        begin
            next_keep.strap = keep.supply_level;
        end
        // software clears with a 0; a new event wins the same cycle
        if (wr && (addr == off_watchdog_control) && !wdata[wdc_cause_bit])
        begin
            next_keep.cause = 1'b0;
        end
        if (cause_event)
        begin
            next_keep.cause = 1'b1;
        end
    end

    // system reset domain register
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state <= '0;
            state.armed <= 1'b0;
            state.watchdog_rate_select <= watchdog_rate_reset;
            state.pattern <= integrity_pattern;
            state.periodic_rate_select <= periodic_rate_reset;
        end
        else
        begin
            state <= next_state;
        end
    end

    // power-up domain register, untouched by system reset
    always_ff @(posedge clk or posedge power_on_reset)
    begin
        if (power_on_reset)
        begin
            keep <= '0;
        end
        else
        begin
            keep <= next_keep;
        end
    end

    // outputs straight from flip-flops
    assign rdata = state.read_data;
    assign periodic_irq = state.irq_pending;
    assign system_reset_req = state.reset_req;
    assign watchdog_reset_cause = keep.cause;

endmodule

// >>> wd_periodic_props.sv
/*
 * checker for the watchdog and periodic interrupt timer ports.
 * assumes one clock domain, reset async high, bus strobes one cycle.
 */
`timescale 1ns/100ps
module wd_periodic_props
    import wd_periodic_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic power_on_reset,
    input wire logic slow_tick,
    input wire logic halt,
    input wire logic programming_supply_pin,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic periodic_irq,
    input wire logic periodic_irq_ack,
    input wire logic system_reset_req,
    input wire logic watchdog_reset_cause
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // service key writes
    sequence s_arm;
        wr && addr == off_service_key && wdata == key_arm;
    endsequence
    sequence s_clear;
        wr && addr == off_service_key && wdata == key_clear;
    endsequence
    // periodic count clear then read
    sequence s_pc_clear_read;
        wr && addr == off_periodic_count ##2 rd && addr == off_periodic_count;
    endsequence

    property p_bad_key;
        wr && addr == off_service_key && wdata != key_arm
            && wdata != key_clear |=> system_reset_req && watchdog_reset_cause;
    endproperty
    a_bad_key: assert property (p_bad_key)
        else $error("bad key write gave no reset");

    property p_pattern;
        wr && addr == off_watchdog_control
            && wdata[wdc_pattern_hi:wdc_pattern_lo] != integrity_pattern
            |-> ##2 system_reset_req [*8];
    endproperty
    a_pattern: assert property (p_pattern)
        else $error("bad pattern did not hold reset");

    property p_rdata_idle;
        !rd |=> rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside read slot");

    property p_key_clear;
        s_arm ##2 s_clear ##2 (rd && addr == off_watchdog_count)
            |=> rdata <= 8'h02;
    endproperty
    a_key_clear: assert property (p_key_clear)
        else $error("key sequence did not clear count");

    property p_pc_clear;
        s_pc_clear_read |=> rdata <= 8'h02;
    endproperty
    a_pc_clear: assert property (p_pc_clear)
        else $error("periodic count not cleared");

    property p_irq_ack;
        periodic_irq && periodic_irq_ack && !slow_tick |=> !periodic_irq;
    endproperty
    a_irq_ack: assert property (p_irq_ack)
        else $error("ack did not drop request");

    property p_allow_clear;
        wr && addr == off_periodic_control && !wdata[pc_allow_bit]
            |=> !periodic_irq;
    endproperty
    a_allow_clear: assert property (p_allow_clear)
        else $error("request kept after allow cleared");

    property p_irq_tick;
        !slow_tick |=> !$rose(periodic_irq);
    endproperty
    a_irq_tick: assert property (p_irq_tick)
        else $error("request raised without a tap");

    property p_halt;
        halt |=> !$rose(periodic_irq);
    endproperty
    a_halt: assert property (p_halt)
        else $error("request raised in halt");
endmodule

bind wd_periodic_timer wd_periodic_props u_props (.clk(clk), .reset(reset),
    .power_on_reset(power_on_reset), .slow_tick(slow_tick), .halt(halt),
    .programming_supply_pin(programming_supply_pin), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .periodic_irq(periodic_irq), .periodic_irq_ack(periodic_irq_ack),
    .system_reset_req(system_reset_req),
    .watchdog_reset_cause(watchdog_reset_cause));

// >>> watchdog_periodic_interrupt_timer_tb.sv
/*
 * self-checking bench for the watchdog and periodic interrupt timer.
 * assumes the bench is bus master, tick source and reset controller.
 */
`timescale 1ns/100ps
module watchdog_periodic_interrupt_timer_tb
    import wd_periodic_pkg::*;
;
    typedef struct packed {logic w; logic [7:0] a, d, e;} row_t;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic power_on_reset = 1'b1;
    logic slow_tick = 1'b0;
    logic halt = 1'b0;
    logic programming_supply_pin = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic periodic_irq_ack = 1'b0;
    logic [7:0] rdata;
    logic periodic_irq, system_reset_req, watchdog_reset_cause;
    int err_total = 0;
    int n_compared = 0;
    // first tap after reset, in ticks, per periodic rate code
    int per [8] = '{4, 16, 64, 128, 256, 1024, 4096, 16384};
    // register rows: write flag, offset, data, expected read
    row_t rows [14] = '{
        '{1'b0, off_watchdog_control, 8'h00, 8'h28},
        '{1'b0, off_service_key, 8'h00, 8'h28},
        '{1'b0, off_periodic_control, 8'h00, 8'h00},
        '{1'b0, off_periodic_count, 8'h00, 8'h00},
        '{1'b0, off_watchdog_count, 8'h00, 8'h00},
        '{1'b0, 8'h20, 8'h00, 8'h00},
        '{1'b1, off_periodic_control, 8'h7f, 8'h00},
        '{1'b0, off_periodic_control, 8'h00, 8'h47},
        '{1'b1, off_watchdog_control, 8'h2b, 8'h00},
        '{1'b0, off_watchdog_control, 8'h00, 8'h2b},
        '{1'b1, off_watchdog_count, 8'h12, 8'h00},
        '{1'b0, off_watchdog_count, 8'h00, 8'h00},
        '{1'b1, off_periodic_control, 8'h00, 8'h00},
        '{1'b1, off_watchdog_control, 8'h28, 8'h00}};

    // 50 mhz clock
    initial
    begin
        forever #10 clk = ~clk;
    end

    wd_periodic_timer DUT (.clk(clk), .reset(reset),
        .power_on_reset(power_on_reset), .slow_tick(slow_tick),
        .halt(halt), .programming_supply_pin(programming_supply_pin),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .periodic_irq(periodic_irq), .periodic_irq_ack(periodic_irq_ack),
        .system_reset_req(system_reset_req),
        .watchdog_reset_cause(watchdog_reset_cause));

    // byte compare, counts every call
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e)
        begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        chk8({7'h00, g}, {7'h00, e});
    endtask
    // one-cycle write strobe
    task automatic bw(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    // one-cycle read, data taken in the following cycle
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk8(rdata, e);
    endtask
    task automatic key(input logic [7:0] d);
        bw(off_service_key, d);
    endtask
    // n slow ticks, one every other cycle
    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge clk);
            slow_tick <= 1'b1;
            @(posedge clk);
            slow_tick <= 1'b0;
        end
        #1;
    endtask
    // reset pulse, supply pin strapped during it
    task automatic rst(input logic p);
        @(posedge clk);
        reset <= 1'b1;
        programming_supply_pin <= p;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        #1;
    endtask
    // bounded wait for a reset demand
    task automatic wait_req;
        for (int i = 0; i < 6; i++)
            if (system_reset_req !== 1'b1)
                @(negedge clk);
    endtask
    task automatic stop_test;
        $display("errors %0d compared %0d", err_total, n_compared);
        if (err_total == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // hang guard, run is about 0.93 ms
    initial
    begin
        #2000000;
        err_total++;
        stop_test();
    end

    initial
    begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        power_on_reset <= 1'b0;
        // reset values and access kinds
        foreach (rows[i])
            if (rows[i].w)
                bw(rows[i].a, rows[i].d);
            else
                rdchk(rows[i].a, rows[i].e);
        // armed key lost across reset, unarmed clear ignored
        key(key_arm);
        rst(1'b0);
        tick(10);
        key(key_clear);
        rdchk(off_watchdog_count, 8'h0a);
        key(key_arm);
        key(key_arm);
        key(key_clear);
        rdchk(off_watchdog_count, 8'h00);
        chk1(system_reset_req, 1'b0);
        // rate codes 1 to 7 each give two counts in twice their divide
        for (int s = 1; s < 8; s++)
        begin
            bw(off_watchdog_control, 8'h28 | 8'(s));
            key(key_arm);
            key(key_clear);
            tick(2 << (s - 1));
            rdchk(off_watchdog_count, 8'h02);
        end
        // clears leave the free prescale alone
        rst(1'b0);
        tick(130);
        rdchk(off_periodic_count, 8'h01);
        bw(off_periodic_count, 8'h00);
        rdchk(off_periodic_count, 8'h00);
        key(key_arm);
        key(key_clear);
        tick(126);
        rdchk(off_periodic_count, 8'h01);
        // overflow: service clears pending, else reset a tick later
        rst(1'b0);
        tick(256);
        rdchk(off_watchdog_count, 8'h00);
        key(key_arm);
        key(key_clear);
        tick(1);
        chk1(system_reset_req, 1'b0);
        tick(255);
        chk1(system_reset_req, 1'b0);
        tick(1);
        wait_req();
        chk1(system_reset_req, 1'b1);
        chk1(watchdog_reset_cause, 1'b1);
        rst(1'b0);
        chk1(watchdog_reset_cause, 1'b1);
        key(8'h23);
        wait_req();
        chk1(system_reset_req, 1'b1);
        rst(1'b0);
        bw(off_watchdog_control, 8'h28);
        rdchk(off_watchdog_control, 8'h28);
        key(8'h23);
        wait_req();
        chk1(system_reset_req, 1'b1);
        chk1(watchdog_reset_cause, 1'b1);
        rst(1'b0);
        // damaged pattern holds reset
        bw(off_watchdog_control, 8'h18);
        wait_req();
        repeat (10) @(negedge clk);
        chk1(system_reset_req, 1'b1);
        // defeat works only with the strap high
        rst(1'b0);
        bw(off_watchdog_control, 8'h68);
        tick(5);
        rdchk(off_watchdog_count, 8'h05);
        rst(1'b1);
        bw(off_watchdog_control, 8'h68);
        tick(5);
        rdchk(off_watchdog_count, 8'h00);
        // first tap of every periodic rate code
        for (int s = 0; s < 8; s++)
        begin
            rst(1'b0);
            bw(off_periodic_control, 8'(s));
            tick(per[s] - 1);
            rdchk(off_periodic_control, 8'(s));
            tick(1);
            rdchk(off_periodic_control, 8'h80 | 8'(s));
        end
        // request, ack, withdraw, software flag, halt
        rst(1'b0);
        tick(4);
        rdchk(off_periodic_control, 8'h80);
        bw(off_periodic_control, 8'h40);
        tick(3);
        chk1(periodic_irq, 1'b0);
        tick(1);
        chk1(periodic_irq, 1'b1);
        @(posedge clk);
        periodic_irq_ack <= 1'b1;
        @(posedge clk);
        periodic_irq_ack <= 1'b0;
        #1 chk1(periodic_irq, 1'b0);
        tick(4);
        bw(off_periodic_control, 8'h00);
        chk1(periodic_irq, 1'b0);
        bw(off_periodic_control, 8'hc0);
        chk1(periodic_irq, 1'b0);
        bw(off_periodic_control, 8'h40);
        rdchk(off_periodic_control, 8'h40);
        @(posedge clk);
        halt <= 1'b1;
        tick(8);
        chk1(periodic_irq, 1'b0);
        rdchk(off_periodic_control, 8'h40);
        @(posedge clk);
        halt <= 1'b0;
        tick(4);
        chk1(periodic_irq, 1'b1);
        stop_test();
    end
endmodule
